// ---- core/eec_pkg.sv ----
// Package of constants and types for the edge event counter
package eec_pkg;

   // ******************************************************
   // Register indices (byte address is four times index)
   // ******************************************************
   localparam int unsigned EEC_ADDR_W     = 18;
   localparam logic [15:0] EEC_IDX_CTRL   = 16'hFFC6;
   localparam logic [15:0] EEC_IDX_COUNT  = 16'hFFC7;
   localparam logic [15:0] EEC_IDX_PORTFN = 16'hFFD0;
   localparam logic [15:0] EEC_IDX_STATUS = 16'hFFD1;
   localparam logic [15:0] EEC_IDX_MASK   = 16'hFFD2;

   // ******************************************************
   // Field positions and reset values
   // ******************************************************
   localparam int unsigned EEC_CLR_BIT    = 7;
   localparam int unsigned EEC_EDG_BIT    = 0;
   localparam int unsigned EEC_EVT_BIT    = 0;
   localparam int unsigned EEC_OVF_BIT    = 0;
   localparam logic [7:0]  EEC_CTRL_RST   = 8'h7E;
   localparam logic [7:0]  EEC_CTRL_RSVD  = 8'h7E;
   localparam logic [7:0]  EEC_COUNT_RST  = 8'h00;
   localparam logic [7:0]  EEC_COUNT_MAX  = 8'hFF;
   localparam logic        EEC_EDG_RST    = 1'b0;
   localparam logic        EEC_EVT_RST    = 1'b0;
   localparam logic        EEC_EN_RST     = 1'b0;

   // ******************************************************
   // Bus answers
   // ******************************************************
   localparam logic [1:0]  EEC_RESP_OKAY  = 2'h0;
   localparam logic [1:0]  EEC_RESP_SLV   = 2'h2;

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
   } eec_det_state_t;

endpackage

// ---- core/eec_edge_if.sv ----
// Interface between the counter core and its pin edge detector
`timescale 1ns/10ps
`default_nettype none
interface eec_edge_if;
   logic pin;
   logic rise_sel;
   logic enable;
   logic pulse;
   modport det  (input pin, input rise_sel, input enable, output pulse);
   modport core (output pin, output rise_sel, output enable, input pulse);
endinterface
`default_nettype wire

// ---- core/eec_edge_det.sv ----
// Synchroniser and single-pulse edge detector for the event pin
`timescale 1ns/10ps
`default_nettype none
module eec_edge_det
   import eec_pkg::*;
(
   // Clock and reset
   input  wire logic clk_sys_in,
   input  wire logic resetn_in,
   // Link to counter core
   eec_edge_if.det   edge_if
);
   import eec_pkg::*;

   eec_det_state_t st_r;
   eec_det_state_t st_nxt;
   logic           rise;
   logic           fall;

   always_comb begin
      st_nxt    = st_r;
      st_nxt.s1 = edge_if.pin;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
   end

   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Only s2/s3 are looked at; s1 may be metastable
   assign rise = st_r.s2 & ~st_r.s3;
   assign fall = ~st_r.s2 & st_r.s3;
   assign edge_if.pulse = edge_if.enable &
                          (edge_if.rise_sel ? rise : fall);

   // ******************************************************
   // Assertions
   // ******************************************************
   default clocking dc @(posedge clk_sys_in); endclocking
   default disable iff (!resetn_in);

   edge_sel_a: assert property (
      edge_if.pulse |->
      (edge_if.rise_sel ? ($past(st_r.s2) == 1'b0 && st_r.s2)
                        : ($past(st_r.s2) == 1'b1 && !st_r.s2)))
      else $error("Pulse does not match selected edge");
   pin_gate_a: assert property (!edge_if.enable |-> !edge_if.pulse)
      else $error("Pulse while event function off");
   one_pulse_a: assert property (edge_if.pulse |=> !edge_if.pulse)
      else $error("Edge counted twice");
endmodule
`default_nettype wire

// ---- core/eec_top.sv ----
// Edge event counter with AXI4-Lite register access
//
// Operation
// - An 8-bit up-counter advances by one per detected active edge.
// - Control bit 0 picks falling edges when 0 and rising when 1.
// - An edge at count FF wraps to 00 and sets the overflow flag.
// - The interrupt is raised while flag and its enable are both 1.
// - After wrapping the count carries on up from zero, no reload.
// - Writing 1 to control bit 7 forces the count to 00.
// - The clear bit drops back to 0 by itself after the clear.
// - Writing 0 to control bit 7 does nothing.
// - Control bits 6 to 1 always read 1 and ignore writes.
// - The count is read-only and readable at any time.
// - Reset gives count 00 and control 7E.
// - The pin feeds the counter only when the event function bit is 1.
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
module eec_top
   import eec_pkg::*;
(
   // Clock and reset
   input  wire logic                  clk_sys_in,
   input  wire logic                  resetn_in,
   // Event pin
   input  wire logic                  ext_count_pin_in,
   // Interrupt
   output logic                       irq_out,
   // AXI4-Lite write address
   input  wire logic                  s_axi_awvalid_in,
   output logic                       s_axi_awready_out,
   input  wire logic [EEC_ADDR_W-1:0] s_axi_awaddr_in,
   // AXI4-Lite write data
   input  wire logic                  s_axi_wvalid_in,
   output logic                       s_axi_wready_out,
   input  wire logic [31:0]           s_axi_wdata_in,
   input  wire logic [3:0]            s_axi_wstrb_in,
   // AXI4-Lite write response
   output logic                       s_axi_bvalid_out,
   input  wire logic                  s_axi_bready_in,
   output logic [1:0]                 s_axi_bresp_out,
   // AXI4-Lite read address
   input  wire logic                  s_axi_arvalid_in,
   output logic                       s_axi_arready_out,
   input  wire logic [EEC_ADDR_W-1:0] s_axi_araddr_in,
   // AXI4-Lite read data
   output logic                       s_axi_rvalid_out,
   input  wire logic                  s_axi_rready_in,
   output logic [31:0]                s_axi_rdata_out,
   output logic [1:0]                 s_axi_rresp_out
);
   import eec_pkg::*;

   // ******************************************************
   // State
   // ******************************************************
   typedef struct packed {
      logic                  aw_held;
      logic [EEC_ADDR_W-1:0] aw_addr;
      logic                  w_held;
      logic [7:0]            w_data;
      logic                  w_lane0;
      logic                  bvalid;
      logic [1:0]            bresp;
      logic                  rvalid;
      logic [31:0]           rdata;
      logic [1:0]            rresp;
      logic [7:0]            count;
      logic                  edge_polarity_select;
      logic                  counter_zero_strobe;
      logic                  event_fn;
      logic                  overflow_request_flag;
      logic                  overflow_irq_enable;
      logic                  irq;
   } eec_state_t;

   localparam logic [EEC_ADDR_W-1:0] ADDR_CTRL   = {EEC_IDX_CTRL,   2'b00};
   localparam logic [EEC_ADDR_W-1:0] ADDR_COUNT  = {EEC_IDX_COUNT,  2'b00};
   localparam logic [EEC_ADDR_W-1:0] ADDR_PORTFN = {EEC_IDX_PORTFN, 2'b00};
   localparam logic [EEC_ADDR_W-1:0] ADDR_STATUS = {EEC_IDX_STATUS, 2'b00};
   localparam logic [EEC_ADDR_W-1:0] ADDR_MASK   = {EEC_IDX_MASK,   2'b00};

   eec_state_t  st_r;
   eec_state_t  st_nxt;
   eec_edge_if  edge_if ();
   logic        do_wr;
   logic        rd_take;
   logic        cnt_edge;
   logic [7:0]  ctrl_view;

   // ******************************************************
   // Pin edge detection
   // ******************************************************
   assign edge_if.pin      = ext_count_pin_in;
   assign edge_if.rise_sel = st_r.edge_polarity_select;
   assign edge_if.enable   = st_r.event_fn;

   eec_edge_det eec_edge_det_i (
      .clk_sys_in (clk_sys_in),
      .resetn_in  (resetn_in),
      .edge_if    (edge_if.det)
   );

   assign cnt_edge = edge_if.pulse;

   // ******************************************************
   // Handshakes
   // ******************************************************
   assign s_axi_awready_out = ~st_r.aw_held;
   assign s_axi_wready_out  = ~st_r.w_held;
   assign s_axi_arready_out = ~st_r.rvalid;
   assign s_axi_bvalid_out  = st_r.bvalid;
   assign s_axi_bresp_out   = st_r.bresp;
   assign s_axi_rvalid_out  = st_r.rvalid;
   assign s_axi_rdata_out   = st_r.rdata;
   assign s_axi_rresp_out   = st_r.rresp;

   // Response must drain before the next write is performed
   assign do_wr   = st_r.aw_held & st_r.w_held & ~st_r.bvalid;
   assign rd_take = s_axi_arvalid_in & ~st_r.rvalid;
   // Reserved bits fixed high
   assign ctrl_view = EEC_CTRL_RSVD
                    | {st_r.counter_zero_strobe, 6'h00,
                       st_r.edge_polarity_select};

   assign irq_out = st_r.irq;

   // ******************************************************
   // Next state
   // ******************************************************
   always_comb begin
      st_nxt = st_r;
      if (s_axi_awvalid_in && !st_r.aw_held) begin
         st_nxt.aw_held = 1'b1;
         st_nxt.aw_addr = s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && !st_r.w_held) begin
         st_nxt.w_held  = 1'b1;
         st_nxt.w_data  = s_axi_wdata_in[7:0];
         st_nxt.w_lane0 = s_axi_wstrb_in[0];
      end
      if (st_r.bvalid && s_axi_bready_in) begin
         st_nxt.bvalid = 1'b0;
      end
      if (st_r.rvalid && s_axi_rready_in) begin
         st_nxt.rvalid = 1'b0;
      end

      // Counting, wrap at the top
      if (cnt_edge) begin
         st_nxt.count = st_r.count + 8'h01;
      end
      // Clear has priority over a coincident edge
      if (st_r.counter_zero_strobe) begin
         st_nxt.count               = EEC_COUNT_RST;
         st_nxt.counter_zero_strobe = 1'b0;
      end

      if (do_wr) begin
         st_nxt.aw_held = 1'b0;
         st_nxt.w_held  = 1'b0;
         st_nxt.bvalid  = 1'b1;
         st_nxt.bresp   = EEC_RESP_OKAY;
         if (st_r.aw_addr == ADDR_CTRL) begin
            if (st_r.w_lane0) begin
               st_nxt.edge_polarity_select = st_r.w_data[EEC_EDG_BIT];
               if (st_r.w_data[EEC_CLR_BIT]) begin
                  st_nxt.counter_zero_strobe = 1'b1;
               end
            end
         end else if (st_r.aw_addr == ADDR_COUNT) begin
            // Count is read-only; write accepted and dropped
            st_nxt.bresp = EEC_RESP_OKAY;
         end else if (st_r.aw_addr == ADDR_PORTFN) begin
            if (st_r.w_lane0) begin
               st_nxt.event_fn = st_r.w_data[EEC_EVT_BIT];
            end
         end else if (st_r.aw_addr == ADDR_STATUS) begin
            if (st_r.w_lane0 && st_r.w_data[EEC_OVF_BIT]) begin
               st_nxt.overflow_request_flag = 1'b0;
            end
         end else if (st_r.aw_addr == ADDR_MASK) begin
            if (st_r.w_lane0) begin
               st_nxt.overflow_irq_enable = st_r.w_data[EEC_OVF_BIT];
            end
         end else begin
            st_nxt.bresp = EEC_RESP_SLV;
         end
      end

      // Set after the clear so a new overflow is never lost
      if (cnt_edge && !st_r.counter_zero_strobe
          && st_r.count == EEC_COUNT_MAX) begin
         st_nxt.overflow_request_flag = 1'b1;
      end

      // Registered so the pin carries no decode glitch
      st_nxt.irq = st_nxt.overflow_request_flag
                 & st_nxt.overflow_irq_enable;

      if (rd_take) begin
         st_nxt.rvalid = 1'b1;
         st_nxt.rresp  = EEC_RESP_OKAY;
         st_nxt.rdata  = 32'h0000_0000;
         if (s_axi_araddr_in == ADDR_CTRL) begin
            st_nxt.rdata[7:0] = ctrl_view;
         end else if (s_axi_araddr_in == ADDR_COUNT) begin
            st_nxt.rdata[7:0] = st_r.count;
         end else if (s_axi_araddr_in == ADDR_PORTFN) begin
            st_nxt.rdata[EEC_EVT_BIT] = st_r.event_fn;
         end else if (s_axi_araddr_in == ADDR_STATUS) begin
            st_nxt.rdata[EEC_OVF_BIT] = st_r.overflow_request_flag;
         end else if (s_axi_araddr_in == ADDR_MASK) begin
            st_nxt.rdata[EEC_OVF_BIT] = st_r.overflow_irq_enable;
         end else begin
            st_nxt.rresp = EEC_RESP_SLV;
         end
      end
   end

   // ******************************************************
   // Registers
   // ******************************************************
   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         st_r                       <= '0;
         st_r.count                 <= EEC_COUNT_RST;
         st_r.edge_polarity_select  <= EEC_EDG_RST;
         st_r.event_fn              <= EEC_EVT_RST;
         st_r.overflow_irq_enable   <= EEC_EN_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ******************************************************
   // Assertions
   // ******************************************************
   default clocking dc @(posedge clk_sys_in); endclocking
   default disable iff (!resetn_in);

   // Counter datapath
   count_step_a: assert property (
      cnt_edge && !st_r.counter_zero_strobe
      && st_r.count != EEC_COUNT_MAX
      |=> st_r.count == $past(st_r.count) + 8'h01)
      else $error("Count did not step by one");

   wrap_flag_a: assert property (
      cnt_edge && !st_r.counter_zero_strobe
      && st_r.count == EEC_COUNT_MAX
      |=> st_r.count == 8'h00 && st_r.overflow_request_flag)
      else $error("Wrap did not zero count and set flag");

   flag_cause_a: assert property (
      $rose(st_r.overflow_request_flag)
      |-> $past(cnt_edge) && !$past(st_r.counter_zero_strobe)
          && $past(st_r.count) == EEC_COUNT_MAX)
      else $error("Overflow flag set without a wrap");

   wrap_resume_a: assert property (
      st_r.overflow_request_flag && st_r.count == 8'h00
      && cnt_edge && !st_r.counter_zero_strobe
      |=> st_r.count == 8'h01)
      else $error("Count did not resume after wrap");

   count_hold_a: assert property (
      !cnt_edge && !st_r.counter_zero_strobe
      |=> st_r.count == $past(st_r.count))
      else $error("Count moved without an edge");

   irq_out_a: assert property (
      irq_out == (st_r.overflow_request_flag
                  && st_r.overflow_irq_enable))
      else $error("Interrupt level wrong");

   // Control and count registers
   clear_zero_a: assert property (
      do_wr && st_r.aw_addr == ADDR_CTRL
      && st_r.w_lane0 && st_r.w_data[EEC_CLR_BIT]
      |=> st_r.counter_zero_strobe ##1
          (st_r.count == 8'h00 && !st_r.counter_zero_strobe))
      else $error("Clear did not zero count and self clear");

   strobe_drop_a: assert property (
      st_r.counter_zero_strobe
      |=> !st_r.counter_zero_strobe && st_r.count == 8'h00)
      else $error("Clear bit did not drop after one cycle");

   clear_zero_noop_a: assert property (
      do_wr && st_r.aw_addr == ADDR_CTRL
      && !st_r.w_data[EEC_CLR_BIT] && !st_r.counter_zero_strobe
      |=> !st_r.counter_zero_strobe)
      else $error("Writing zero started a clear");

   edge_write_a: assert property (
      do_wr && st_r.aw_addr == ADDR_CTRL && st_r.w_lane0
      |=> st_r.edge_polarity_select == $past(st_r.w_data[EEC_EDG_BIT]))
      else $error("Edge select not taken from write");

   rsvd_read_a: assert property (
      rd_take && s_axi_araddr_in == ADDR_CTRL
      |=> st_r.rdata[6:1] == 6'h3F && st_r.rdata[31:8] == 24'h0)
      else $error("Reserved control bits read wrong");

   count_read_a: assert property (
      rd_take && s_axi_araddr_in == ADDR_COUNT
      |=> st_r.rdata[7:0] == $past(st_r.count))
      else $error("Count read mismatch");

   // Bus side
   lane_off_a: assert property (
      do_wr && !st_r.w_lane0
      |=> $stable(st_r.edge_polarity_select) && $stable(st_r.event_fn)
          && $stable(st_r.overflow_irq_enable))
      else $error("Write with lane 0 off changed a register");

   flag_clear_a: assert property (
      do_wr && st_r.aw_addr == ADDR_STATUS && st_r.w_lane0
      && st_r.w_data[EEC_OVF_BIT] && !cnt_edge
      |=> !st_r.overflow_request_flag)
      else $error("Status write of one did not clear flag");

   wr_answer_a: assert property (
      do_wr |=> s_axi_bvalid_out)
      else $error("Write not answered in the next cycle");

   rd_answer_a: assert property (
      rd_take |=> s_axi_rvalid_out)
      else $error("Read not answered in the next cycle");

   unmapped_wr_a: assert property (
      do_wr && st_r.aw_addr != ADDR_CTRL && st_r.aw_addr != ADDR_COUNT
      && st_r.aw_addr != ADDR_PORTFN && st_r.aw_addr != ADDR_STATUS
      && st_r.aw_addr != ADDR_MASK |=> s_axi_bresp_out == EEC_RESP_SLV)
      else $error("Unmapped write not refused");

   wrap_c: cover property (cnt_edge && st_r.count == EEC_COUNT_MAX);
   irq_c: cover property (irq_out ##1 !st_r.overflow_request_flag);
   clear_c: cover property (st_r.counter_zero_strobe && cnt_edge);
   unmapped_c: cover property (st_r.bvalid && st_r.bresp == EEC_RESP_SLV);
   lane_off_c: cover property (do_wr && !st_r.w_lane0);
endmodule
`default_nettype wire

// ---- dv/eec_event_src.sv ----
// Model of the external event source that drives the counter pin
`timescale 1ns/10ps
`default_nettype none
module eec_event_src (
   // Clock
   input  wire logic clk_sys_in,
   // Event pin
   output logic      pin_out
);
   initial pin_out = 1'b0;

   // ****************************************
   // Pin drive tasks
   // ****************************************
   task automatic set_level(input logic lvl);
      @(posedge clk_sys_in);
      pin_out <= lvl;
   endtask

   // Gap of 1 gives two-clock levels; the synchroniser also takes one-clock levels
   task automatic pulses(input int n, input int gap);
      repeat (n) begin
         set_level(1'b1);
         repeat (gap) @(posedge clk_sys_in);
         set_level(1'b0);
         repeat (gap) @(posedge clk_sys_in);
      end
   endtask
endmodule
`default_nettype wire

// ---- dv/test_edge_event_counter.sv ----
// Self-checking bench for the edge event counter
`timescale 1ns/10ps
`default_nettype none
module test_edge_event_counter;
   import eec_pkg::*;
   localparam logic [EEC_ADDR_W-1:0] a_ctrl = {EEC_IDX_CTRL, 2'b00};
   localparam logic [EEC_ADDR_W-1:0] a_cnt  = {EEC_IDX_COUNT, 2'b00};
   localparam logic [EEC_ADDR_W-1:0] a_fn   = {EEC_IDX_PORTFN, 2'b00};
   localparam logic [EEC_ADDR_W-1:0] a_st   = {EEC_IDX_STATUS, 2'b00};
   localparam logic [EEC_ADDR_W-1:0] a_msk  = {EEC_IDX_MASK, 2'b00};
   localparam logic [EEC_ADDR_W-1:0] a_bad  = a_msk + 18'h00004;
   localparam logic [EEC_ADDR_W-1:0] a_mis  = a_ctrl | 18'h00001;
   localparam logic [1:0]            ok     = EEC_RESP_OKAY;
   localparam logic [1:0]            slv    = EEC_RESP_SLV;

   logic                  clk_sys_in = 1'b0;
   logic                  resetn_in;
   logic                  pin, irq;
   logic                  awvalid, awready, wvalid, wready, bvalid, bready;
   logic                  arvalid, arready, rvalid, rready;
   logic [EEC_ADDR_W-1:0] awaddr, araddr;
   logic [31:0]           wdata, rdata;
   logic [3:0]            wstrb;
   logic [1:0]            bresp, rresp;
   int                    failures = 0;
   int                    tests_run = 0;

   always #2 clk_sys_in = ~clk_sys_in;

   eec_event_src eec_event_src_i (.clk_sys_in(clk_sys_in), .pin_out(pin));

   eec_top eec_top_i (
      .clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
      .ext_count_pin_in(pin), .irq_out(irq),
      .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
      .s_axi_awaddr_in(awaddr), .s_axi_wvalid_in(wvalid),
      .s_axi_wready_out(wready), .s_axi_wdata_in(wdata),
      .s_axi_wstrb_in(wstrb), .s_axi_bvalid_out(bvalid),
      .s_axi_bready_in(bready), .s_axi_bresp_out(bresp),
      .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
      .s_axi_araddr_in(araddr), .s_axi_rvalid_out(rvalid),
      .s_axi_rready_in(rready), .s_axi_rdata_out(rdata),
      .s_axi_rresp_out(rresp));

   // ****************************************
   // Compare and bus tasks
   // ****************************************
   task automatic chk_word(input string nm, input logic [31:0] e, g);
      tests_run++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk_irq(input logic e);
      @(negedge clk_sys_in);
      tests_run++;
      if (irq !== e) begin
         failures++;
         $display("MISMATCH irq expected %b seen %b", e, irq);
      end
   endtask

   // Ready is looked at on the falling edge, where it is settled
   task automatic axi_wr(input logic [EEC_ADDR_W-1:0] a,
                         input logic [7:0] d, input logic [1:0] er);
      logic ah, wh, bh, done;
      logic [1:0] r;
      done = 1'b0;
      r = 2'h3;
      @(posedge clk_sys_in);
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      awaddr <= a;
      wdata <= {24'h000000, d};
      bready <= 1'b1;
      while (!done) begin
         @(negedge clk_sys_in);
         ah = awvalid & awready;
         wh = wvalid & wready;
         bh = (bvalid === 1'b1);
         if (bh) r = bresp;
         @(posedge clk_sys_in);
         if (ah) awvalid <= 1'b0;
         if (wh) wvalid <= 1'b0;
         if (bh) begin
            bready <= 1'b0;
            done = 1'b1;
         end
      end
      chk_word("bresp", {30'h0, er}, {30'h0, r});
   endtask

   task automatic axi_rd(input logic [EEC_ADDR_W-1:0] a,
                         input logic [1:0] er, input logic [7:0] ed);
      logic ah, rh, done;
      logic [31:0] d;
      logic [1:0] r;
      done = 1'b0;
      @(posedge clk_sys_in);
      arvalid <= 1'b1;
      araddr <= a;
      rready <= 1'b1;
      while (!done) begin
         @(negedge clk_sys_in);
         ah = arvalid & arready;
         rh = (rvalid === 1'b1);
         d = rdata;
         r = rresp;
         @(posedge clk_sys_in);
         if (ah) arvalid <= 1'b0;
         if (rh) begin
            rready <= 1'b0;
            done = 1'b1;
         end
      end
      chk_word("rresp", {30'h0, er}, {30'h0, r});
      chk_word("rdata", {24'h000000, ed}, d);
   endtask

   // Pin edge reaches the count three clocks later
   task automatic settle();
      repeat (6) @(posedge clk_sys_in);
   endtask

   task automatic stop_test();
      $display("tests_run %0d failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // ****************************************
   // Watchdog
   // ****************************************
   initial begin
      repeat (8000) @(posedge clk_sys_in);
      failures++;
      stop_test();
   end

   // ****************************************
   // Test sequence
   // ****************************************
   initial begin
      resetn_in <= 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} <= 5'h00;
      awaddr <= 18'h00000;
      araddr <= 18'h00000;
      wdata <= 32'h00000000;
      wstrb <= 4'hF;
      repeat (16) @(posedge clk_sys_in);
      resetn_in <= 1'b1;
      axi_rd(a_ctrl, ok, EEC_CTRL_RST);
      axi_rd(a_cnt, ok, EEC_COUNT_RST);
      axi_rd(a_st, ok, 8'h00);
      axi_rd(a_msk, ok, 8'h00);
      axi_rd(a_fn, ok, 8'h00);
      chk_irq(1'b0);
      eec_event_src_i.pulses(3, 1);
      settle();
      axi_rd(a_cnt, ok, 8'h00);
      axi_wr(a_fn, 8'h01, ok);
      eec_event_src_i.set_level(1'b1);
      settle();
      axi_rd(a_cnt, ok, 8'h00);
      eec_event_src_i.set_level(1'b0);
      settle();
      axi_rd(a_cnt, ok, 8'h01);
      axi_wr(a_ctrl, 8'h01, ok);
      axi_rd(a_ctrl, ok, 8'h7F);
      eec_event_src_i.set_level(1'b1);
      settle();
      axi_rd(a_cnt, ok, 8'h02);
      eec_event_src_i.set_level(1'b0);
      settle();
      axi_rd(a_cnt, ok, 8'h02);
      axi_wr(a_ctrl, 8'h00, ok);
      axi_rd(a_ctrl, ok, 8'h7E);
      axi_rd(a_cnt, ok, 8'h02);
      axi_wr(a_cnt, 8'h55, ok);
      axi_rd(a_cnt, ok, 8'h02);
      axi_wr(a_ctrl, 8'h80, ok);
      axi_rd(a_cnt, ok, 8'h00);
      axi_rd(a_ctrl, ok, 8'h7E);
      eec_event_src_i.pulses(255, 1);
      settle();
      axi_rd(a_cnt, ok, EEC_COUNT_MAX);
      axi_rd(a_st, ok, 8'h00);
      eec_event_src_i.pulses(1, 2);
      settle();
      axi_rd(a_cnt, ok, 8'h00);
      axi_rd(a_st, ok, 8'h01);
      chk_irq(1'b0);
      axi_wr(a_msk, 8'h01, ok);
      chk_irq(1'b1);
      eec_event_src_i.pulses(2, 2);
      settle();
      axi_rd(a_cnt, ok, 8'h02);
      axi_wr(a_st, 8'h01, ok);
      axi_rd(a_st, ok, 8'h00);
      chk_irq(1'b0);
      wstrb <= 4'h0;
      axi_wr(a_ctrl, 8'h81, ok);
      axi_rd(a_ctrl, ok, 8'h7E);
      axi_rd(a_cnt, ok, 8'h02);
      wstrb <= 4'hF;
      axi_wr(a_bad, 8'hFF, slv);
      axi_rd(a_bad, slv, 8'h00);
      axi_rd(a_mis, slv, 8'h00);
      stop_test();
   end
endmodule
`default_nettype wire
